//--- rtl/dsm_pkg.sv
// Register map, reset values and timing constants of the DPLL status and monitor registers
package dsm_pkg;
	// Register indices; the byte address on the bus is four times the index
	localparam logic [7:0] IDX_HOLD_MASK = 8'h34;
	localparam logic [7:0] IDX_STATE     = 8'h44;
	localparam logic [7:0] IDX_FB        = 8'h45;
	localparam logic [7:0] IDX_PWR       = 8'h46;
	localparam logic [7:0] IDX_PML0      = 8'h47;
	localparam logic [7:0] IDX_PML1      = 8'h48;
	localparam logic [7:0] IDX_MON0      = 8'h4b;
	localparam logic [7:0] IDX_FAIL      = 8'h60;
	localparam logic [7:0] IDX_IRQ_ST    = 8'h61;
	localparam logic [7:0] IDX_IRQ_MASK  = 8'h62;

	// Reset values
	localparam logic [7:0] RST_HOLD_MASK = 8'h87;
	localparam logic [7:0] RST_FB        = 8'h00;
	localparam logic [7:0] RST_PWR       = 8'h00;
	localparam logic [7:0] RST_PML       = 8'h02;
	localparam logic [7:0] RST_MON0      = 8'h55;
	localparam logic [5:0] RST_IRQ_MASK  = 6'h00;

	// Writable bits; everything else keeps its reset value
	localparam logic [7:0] WM_HOLD_MASK  = 8'h0f;
	localparam logic [7:0] WM_FB         = 8'h84;
	localparam logic [7:0] WM_PWR        = 8'h0f;
	localparam logic [7:0] WM_PML        = 8'hff;
	localparam logic [7:0] WM_MON0       = 8'h77;

	// Field positions
	localparam int FB_SRC_BIT   = 2;
	localparam int FB_EN_BIT    = 7;
	localparam int STATE_HOLD   = 0;
	localparam int STATE_LOCK   = 1;
	localparam int CFM_LSB      = 0;
	localparam int SCM_LSB      = 4;
	// Bits of the synchronised status vector and of the interrupt status
	localparam int EV_HOLD      = 0;
	localparam int EV_LOCK      = 1;
	localparam int EV_LOS       = 2;
	localparam int EV_SCM       = 3;
	localparam int EV_CFM       = 4;
	localparam int EV_GST       = 5;
	localparam int EV_W         = 6;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Timing
	localparam int CLK_PERIOD_NS  = 10;
	localparam int PML_UNIT_US    = 10;
	localparam int PML_UNIT_CYC   = (PML_UNIT_US * 1000) / CLK_PERIOD_NS;
	localparam int BOUND_W        = 18;
	localparam int SCM_SAMPLE_MHZ = 800;
	localparam int SCM_RES_PS     = 1000000 / SCM_SAMPLE_MHZ;
endpackage : dsm_pkg

//--- rtl/dsm_sync.sv
// Three-stage synchroniser for monitor and DPLL status levels
`timescale 1ns/1ps
module dsm_sync #(
	parameter int W = 6
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] out;
	} dsm_sync_s;

	dsm_sync_s sync_reg;
	dsm_sync_s sync_next;

	if (W < 1) begin : g_bad_w
		$error("dsm_sync: W must be at least 1");
	end

	// A bit changes only once stages two and three agree, filtering a half-settled edge
	always_comb begin
		sync_next = sync_reg;
		sync_next.s1 = async_in;
		sync_next.s2 = sync_reg.s1;
		sync_next.s3 = sync_reg.s2;
		for (int i = 0; i < W; i++) begin
			if (sync_reg.s2[i] == sync_reg.s3[i]) begin
				sync_next.out[i] = sync_reg.s3[i];
			end
		end
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_reg <= '0;
		end else begin
			sync_reg <= sync_next;
		end
	end

	assign sync_out = sync_reg.out;
endmodule : dsm_sync

//--- rtl/dsm_regs.sv
// DPLL status, feedback, output power, phase memory and reference 0 monitor registers
//
// Contract
// RULE_01 - Status bit 0 reads high while the DPLL is in holdover; never masked.
// RULE_02 - Status bit 1 reads high while the DPLL is locked; never masked.
// RULE_03 - Feedback control bit 2 picks ref0 or ref1 as external feedback source.
// RULE_04 - Feedback control bit 7 high enables external feedback; low disables it.
// RULE_05 - With feedback enabled, main reference and feedback must be frequency locked.
// RULE_06 - Bits 3:0 put differential outputs 0 to 3 in reduced power when set.
// RULE_07 - Ref0 phase memory limit is an 8-bit count of 10 us units.
// RULE_08 - Ref1 phase memory limit is an 8-bit count of 10 us units.
// RULE_09 - Software programs each phase memory limit to at least one reference period.
// RULE_10 - Ref0 limit bits 2:0 select coarse frequency tolerance; excess raises failure.
// RULE_11 - Ref0 coarse frequency failure is readable in the failure indicator register.
// RULE_12 - Ref0 limit bits 6:4 select single cycle tolerance; violation raises failure.
// RULE_13 - Single cycle monitor samples ref0 at 800 MHz, 1.25 ns resolution.
// RULE_14 - Software picks single cycle tolerance to suit reference frequency.
// RULE_15 - Above 400 MHz software masks and ignores the single cycle indicator.
// RULE_16 - Holdover follows a failure only when its holdover mask bit is set.
// RULE_17 - Reserved bits keep their reset value and have no effect.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module dsm_regs #(
	parameter int ADDR_W = 12
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              dpll_in_holdover,
	input  wire logic              dpll_locked,
	input  wire logic              ref0_fail_los,
	input  wire logic              ref0_fail_scm,
	input  wire logic              ref0_fail_cfm,
	input  wire logic              ref0_fail_gst,
	output logic                   feedback_source_choice,
	output logic                   feedback_use_enable,
	output logic                   out0_low_power,
	output logic                   out1_low_power,
	output logic                   out2_low_power,
	output logic                   out3_low_power,
	output logic [dsm_pkg::BOUND_W-1:0] ref0_phase_history_bound,
	output logic [dsm_pkg::BOUND_W-1:0] ref1_phase_history_bound,
	output logic [2:0]             ref0_coarse_freq_tolerance,
	output logic [2:0]             ref0_period_tolerance,
	output logic                   holdover_request,
	output logic                   irq
);
	import dsm_pkg::*;

	typedef struct packed {
		logic                 awready;
		logic                 wready;
		logic                 arready;
		logic                 aw_full;
		logic [ADDR_W-1:0]    aw_addr;
		logic                 w_full;
		logic [7:0]           w_data;
		logic                 w_strb0;
		logic                 bvalid;
		logic [1:0]           bresp;
		logic                 rvalid;
		logic [7:0]           rdata;
		logic [1:0]           rresp;
		logic [7:0]           hmask;
		logic [7:0]           fb;
		logic [7:0]           pwr;
		logic [7:0]           pml0;
		logic [7:0]           pml1;
		logic [7:0]           mon0;
		logic [EV_W-1:0]      prev;
		logic [EV_W-1:0]      irq_st;
		logic [EV_W-1:0]      irq_mask;
		logic                 irq;
		logic                 hold_req;
		logic [BOUND_W-1:0]   bound0;
		logic [BOUND_W-1:0]   bound1;
	} dsm_state_s;

	dsm_state_s         st_reg;
	dsm_state_s         st_next;
	logic [EV_W-1:0]    sync_q;
	logic               wr_go;
	logic               wr_fire;

	if (ADDR_W < 10) begin : g_bad_addr
		$error("dsm_regs: ADDR_W must reach the highest register");
	end

	// Does a byte address hit a register index; upper bits must be zero
	function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
		return (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
	endfunction : addr_hit

	// Phase memory count to clock cycles, 255 counts fit in BOUND_W bits
	function automatic logic [BOUND_W-1:0] to_cycles(input logic [7:0] cnt);
		return BOUND_W'(32'(cnt) * PML_UNIT_CYC);
	endfunction : to_cycles

	// Merge a byte write into a register, keeping reserved bits
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
		input logic [7:0] wm);
		return (wd & wm) | (old & ~wm);
	endfunction : merge

	// Status pins arrive from the monitor clock domain
	dsm_sync #(
		.W(EV_W)
	) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.async_in({ref0_fail_gst, ref0_fail_cfm, ref0_fail_scm, ref0_fail_los,
			dpll_locked, dpll_in_holdover}),
		.sync_out(sync_q)
	);

	// Write happens once address and data are both held and no response is pending
	assign wr_go   = st_reg.aw_full && st_reg.w_full && !st_reg.bvalid;
	assign wr_fire = wr_go && st_reg.w_strb0;

	// Bus slave, register updates, events and derived outputs
	always_comb begin
		logic [EV_W-1:0] ev;
		logic [EV_W-1:0] clr;
		logic [7:0]      idx;
		ev  = sync_q & ~st_reg.prev;
		clr = '0;
		idx = 8'h00;
		st_next = st_reg;
		st_next.prev = sync_q;

		// Address and data are taken independently, in either order
		if (s_axi_awvalid && st_reg.awready) begin
			st_next.aw_full = 1'b1;
			st_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_reg.wready) begin
			st_next.w_full  = 1'b1;
			st_next.w_data  = s_axi_wdata[7:0];
			st_next.w_strb0 = s_axi_wstrb[0];
		end
		if (s_axi_bready && st_reg.bvalid) begin
			st_next.bvalid = 1'b0;
		end

		// Register write; only byte lane 0 carries data
		if (wr_go) begin
			st_next.aw_full = 1'b0;
			st_next.w_full  = 1'b0;
			st_next.bvalid  = 1'b1;
			st_next.bresp   = RESP_OKAY;
			idx = st_reg.aw_addr[9:2];
			if (!addr_hit(st_reg.aw_addr, idx)) begin
				st_next.bresp = RESP_SLVERR;
			end else if (st_reg.w_strb0) begin
				case (idx)
					IDX_HOLD_MASK: st_next.hmask = merge(st_reg.hmask, st_reg.w_data,
						WM_HOLD_MASK); // [RULE_17]
					IDX_FB:        st_next.fb = merge(st_reg.fb, st_reg.w_data, WM_FB); // [RULE_17]
					IDX_PWR:       st_next.pwr = merge(st_reg.pwr, st_reg.w_data, WM_PWR);
					IDX_PML0:      st_next.pml0 = merge(st_reg.pml0, st_reg.w_data, WM_PML);
					IDX_PML1:      st_next.pml1 = merge(st_reg.pml1, st_reg.w_data, WM_PML);
					IDX_MON0:      st_next.mon0 = merge(st_reg.mon0, st_reg.w_data, WM_MON0);
					IDX_IRQ_ST:    clr = st_reg.w_data[EV_W-1:0];
					IDX_IRQ_MASK:  st_next.irq_mask = st_reg.w_data[EV_W-1:0];
					IDX_STATE, IDX_FAIL: ;
					default:       st_next.bresp = RESP_SLVERR;
				endcase
			end
		end

		// Sticky events; a set in the clearing cycle survives
		st_next.irq_st = (st_reg.irq_st & ~clr) | ev;
		st_next.irq = |(st_next.irq_st & st_next.irq_mask);

		// Read channel; one read outstanding, data one cycle after the address
		if (s_axi_rready && st_reg.rvalid) begin
			st_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st_reg.arready) begin
			st_next.rvalid = 1'b1;
			st_next.rresp  = RESP_OKAY;
			st_next.rdata  = 8'h00;
			idx = s_axi_araddr[9:2];
			if (!addr_hit(s_axi_araddr, idx)) begin
				st_next.rresp = RESP_SLVERR;
			end else begin
				case (idx)
					IDX_HOLD_MASK: st_next.rdata = st_reg.hmask;
					IDX_STATE:     st_next.rdata = {6'h00, sync_q[EV_LOCK],
						sync_q[EV_HOLD]}; // [RULE_01] [RULE_02]
					IDX_FB:        st_next.rdata = st_reg.fb;
					IDX_PWR:       st_next.rdata = st_reg.pwr;
					IDX_PML0:      st_next.rdata = st_reg.pml0;
					IDX_PML1:      st_next.rdata = st_reg.pml1;
					IDX_MON0:      st_next.rdata = st_reg.mon0;
					IDX_FAIL:      st_next.rdata = {4'h0, sync_q[EV_GST:EV_LOS]}; // [RULE_11]
					IDX_IRQ_ST:    st_next.rdata = {2'b00, st_reg.irq_st};
					IDX_IRQ_MASK:  st_next.rdata = {2'b00, st_reg.irq_mask};
					default:       st_next.rresp = RESP_SLVERR;
				endcase
			end
		end

		// Holdover only on failures whose mask bit is set
		st_next.hold_req = |(sync_q[EV_GST:EV_LOS] & st_reg.hmask[3:0]); // [RULE_16]
		// Limits to cycles ahead of time, so the datapath sees a plain compare
		st_next.bound0 = to_cycles(st_next.pml0); // [RULE_07]
		st_next.bound1 = to_cycles(st_next.pml1); // [RULE_08]

		// Ready flags registered so every bus output comes from a flop
		st_next.awready = !st_next.aw_full && !st_next.bvalid;
		st_next.wready  = !st_next.w_full && !st_next.bvalid;
		st_next.arready = !st_next.rvalid;
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg          <= '0;
			st_reg.hmask    <= RST_HOLD_MASK;
			st_reg.fb       <= RST_FB;
			st_reg.pwr      <= RST_PWR;
			st_reg.pml0     <= RST_PML;
			st_reg.pml1     <= RST_PML;
			st_reg.mon0     <= RST_MON0;
			st_reg.irq_mask <= RST_IRQ_MASK;
			st_reg.bound0   <= BOUND_W'(2 * PML_UNIT_CYC);
			st_reg.bound1   <= BOUND_W'(2 * PML_UNIT_CYC);
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state register
	assign s_axi_awready = st_reg.awready;
	assign s_axi_wready  = st_reg.wready;
	assign s_axi_arready = st_reg.arready;
	assign s_axi_bvalid  = st_reg.bvalid;
	assign s_axi_bresp   = st_reg.bresp;
	assign s_axi_rvalid  = st_reg.rvalid;
	assign s_axi_rresp   = st_reg.rresp;
	assign s_axi_rdata   = {24'h000000, st_reg.rdata};
	assign feedback_source_choice = st_reg.fb[FB_SRC_BIT]; // [RULE_03]
	assign feedback_use_enable    = st_reg.fb[FB_EN_BIT]; // [RULE_04]
	// Per-output power mode
	assign out0_low_power = st_reg.pwr[0]; // [RULE_06]
	assign out1_low_power = st_reg.pwr[1];
	assign out2_low_power = st_reg.pwr[2];
	assign out3_low_power = st_reg.pwr[3];
	assign ref0_phase_history_bound = st_reg.bound0;
	assign ref1_phase_history_bound = st_reg.bound1;
	// Tolerance codes go raw to the monitors, which sample at SCM_SAMPLE_MHZ
	assign ref0_coarse_freq_tolerance = st_reg.mon0[CFM_LSB +: 3]; // [RULE_10]
	assign ref0_period_tolerance      = st_reg.mon0[SCM_LSB +: 3]; // [RULE_12] [RULE_13]
	assign holdover_request = st_reg.hold_req;
	assign irq              = st_reg.irq;

	hold_flag_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_01]
		(s_axi_arvalid && s_axi_arready && addr_hit(s_axi_araddr, IDX_STATE))
		|=> s_axi_rvalid && s_axi_rdata[STATE_HOLD] == $past(sync_q[EV_HOLD]))
		else $error("holdover flag read wrong");
	lock_flag_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_02]
		(s_axi_arvalid && s_axi_arready && addr_hit(s_axi_araddr, IDX_STATE))
		|=> s_axi_rdata[STATE_LOCK] == $past(sync_q[EV_LOCK]))
		else $error("lock flag read wrong");
	fb_select_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_03]
		(wr_fire && addr_hit(st_reg.aw_addr, IDX_FB))
		|=> feedback_source_choice == $past(st_reg.w_data[FB_SRC_BIT]) && s_axi_bvalid)
		else $error("feedback source not written");
	fb_enable_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_04]
		(wr_fire && addr_hit(st_reg.aw_addr, IDX_FB))
		|=> feedback_use_enable == $past(st_reg.w_data[FB_EN_BIT]))
		else $error("feedback enable not written");
	out_power_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_06]
		(wr_fire && addr_hit(st_reg.aw_addr, IDX_PWR))
		|=> out0_low_power == $past(st_reg.w_data[0]) && out3_low_power == $past(st_reg.w_data[3]))
		else $error("output power bits not written");
	bound_ref0_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_07]
		$past(aresetn) |-> 32'(ref0_phase_history_bound) == 1000 * 32'($past(st_next.pml0)))
		else $error("ref0 phase bound wrong");
	bound_ref1_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_08]
		$past(aresetn) |-> 32'(ref1_phase_history_bound) == 1000 * 32'($past(st_next.pml1)))
		else $error("ref1 phase bound wrong");
	coarse_tol_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_10]
		(wr_fire && addr_hit(st_reg.aw_addr, IDX_MON0))
		|=> ref0_coarse_freq_tolerance == $past(st_reg.w_data[2:0]))
		else $error("coarse tolerance not written");
	fail_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_11]
		(s_axi_arvalid && s_axi_arready && addr_hit(s_axi_araddr, IDX_FAIL))
		|=> s_axi_rdata[2] == $past(sync_q[EV_CFM]))
		else $error("coarse failure read wrong");
	period_tol_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_12]
		(wr_fire && addr_hit(st_reg.aw_addr, IDX_MON0))
		|=> ref0_period_tolerance == $past(st_reg.w_data[6:4]))
		else $error("period tolerance not written");
	hold_mask_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_16]
		$past(aresetn) |-> holdover_request == $past(|(sync_q[EV_GST:EV_LOS] & st_reg.hmask[3:0])))
		else $error("holdover request ignores mask");
	reserved_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_17]
		((st_reg.fb & ~WM_FB) == (RST_FB & ~WM_FB)) && ((st_reg.mon0 & ~WM_MON0) == 8'h00))
		else $error("reserved bit changed");
	irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(aresetn) && !wr_go && (|(sync_q & ~st_reg.prev & st_reg.irq_mask)) |=> irq)
		else $error("interrupt level wrong");
endmodule : dsm_regs

//--- tb/dsm_regs_test.sv
// Self-checking bench for the DPLL status and monitor register block
`timescale 1ns/1ps
module dsm_regs_test;
	import dsm_pkg::*;
	localparam int TIMEOUT_CYC = 20000;
	logic        aclk    = 1'b0;
	logic        aresetn;
	logic [11:0] awaddr, araddr;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb, fail_in, lp;
	logic [1:0]  bresp, rresp;
	logic        hold_in, lock_in, fb_src, fb_en, hold_req, irq;
	logic [17:0] bound0, bound1;
	logic [2:0]  cfm_tol, scm_tol;
	int          error_cnt = 0;
	int          checked   = 0;
	int          cyc       = 0;
	logic [33:0] rq[$];
	logic [1:0]  wq[$];
	logic [33:0] re;
	logic [7:0]  dv[5];
	logic [7:0]  cfg_idx[5] = '{IDX_FB, IDX_PWR, IDX_PML0, IDX_PML1, IDX_MON0};
	logic [7:0]  cfg_rst[5] = '{RST_FB, RST_PWR, RST_PML, RST_PML, RST_MON0};
	logic [7:0]  cfg_wm[5]  = '{WM_FB, WM_PWR, WM_PML, WM_PML, WM_MON0};

	always #5 aclk = ~aclk;

	dsm_regs #(.ADDR_W(12)) i_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.dpll_in_holdover(hold_in), .dpll_locked(lock_in),
		.ref0_fail_los(fail_in[0]), .ref0_fail_scm(fail_in[1]),
		.ref0_fail_cfm(fail_in[2]), .ref0_fail_gst(fail_in[3]),
		.feedback_source_choice(fb_src), .feedback_use_enable(fb_en),
		.out0_low_power(lp[0]), .out1_low_power(lp[1]),
		.out2_low_power(lp[2]), .out3_low_power(lp[3]),
		.ref0_phase_history_bound(bound0), .ref1_phase_history_bound(bound1),
		.ref0_coarse_freq_tolerance(cfm_tol), .ref0_period_tolerance(scm_tol),
		.holdover_request(hold_req), .irq(irq)
	);

	task automatic note_err(input string msg);
		error_cnt++;
		$display("ERROR %0t %s", $time, msg);
	endtask : note_err

	task automatic cmp_rd(input logic [31:0] got, input logic [1:0] gr, input logic [33:0] e);
		checked++;
		if (got !== e[31:0] || gr !== e[33:32])
			note_err($sformatf("read got %h/%b want %h/%b", got, gr, e[31:0], e[33:32]));
	endtask : cmp_rd

	task automatic cmp_wr(input logic [1:0] got, input logic [1:0] e);
		checked++;
		if (got !== e)
			note_err($sformatf("write response %b want %b", got, e));
	endtask : cmp_wr

	task automatic cmp_port(input logic [31:0] got, input logic [31:0] e);
		checked++;
		if (got !== e)
			note_err($sformatf("port value %h want %h", got, e));
	endtask : cmp_port

	// Both channels offered together; each released at its own handshake
	task automatic axi_write(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		wq.push_back(er);
		// Start on a clock edge, so every bus signal changes right after it
		@(posedge aclk);
		awaddr <= {2'b00, idx, 2'b00};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && awready) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!bvalid);
	endtask : axi_write

	task automatic axi_read(input logic [7:0] idx, input logic [31:0] ed, input logic [1:0] er);
		rq.push_back({er, ed});
		@(posedge aclk);
		araddr <= {2'b00, idx, 2'b00};
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
	endtask : axi_read

	task automatic settle(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask : settle

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop

	// Answers are matched to the oldest pending note at their handshake edge
	always @(posedge aclk) begin
		if (rvalid && rready) begin
			if (rq.size() == 0)
				note_err("read answer with no request");
			else begin
				re = rq.pop_front();
				cmp_rd(rdata, rresp, re);
			end
		end
		if (bvalid && bready) begin
			if (wq.size() == 0)
				note_err("write answer with no request");
			else
				cmp_wr(bresp, wq.pop_front());
		end
	end

	// Watchdog so a lost handshake cannot hang the run
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == TIMEOUT_CYC) begin
			note_err("timeout");
			report_and_stop();
		end
	end

	initial begin
		aresetn <= 1'b0;
		{awaddr, araddr, wdata} <= '0;
		{awvalid, wvalid, arvalid} <= 3'b000;
		bready <= 1'b1;
		rready <= 1'b1;
		wstrb <= 4'hf;
		{hold_in, lock_in, fail_in} <= '0;
		void'($urandom(32'hb5d9));
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		settle(4);
		cmp_port({14'h0, bound0}, 32'd2000);
		cmp_port({14'h0, bound1}, 32'd2000);
		cmp_port({26'h0, scm_tol, cfm_tol}, 32'h2d);
		cmp_port({25'h0, fb_en, fb_src, lp, hold_req, irq}, 32'h0);
		for (int i = 0; i < 5; i++)
			axi_read(cfg_idx[i], {24'h0, cfg_rst[i]}, RESP_OKAY);
		axi_read(IDX_HOLD_MASK, {24'h0, RST_HOLD_MASK}, RESP_OKAY);
		axi_read(8'h40, 32'h0, RESP_SLVERR);
		axi_write(8'h40, 8'hff, RESP_SLVERR);
		axi_write(IDX_STATE, 8'hff, RESP_OKAY);
		// Lane 0 strobe low must leave the register untouched
		wstrb <= 4'he;
		axi_write(IDX_PWR, 8'h0f, RESP_OKAY);
		wstrb <= 4'hf;
		axi_read(IDX_PWR, {24'h0, RST_PWR}, RESP_OKAY);
		axi_read(IDX_STATE, 32'h0, RESP_OKAY);
		// Random settings, with every tolerance code walked in both fields
		for (int k = 0; k < 8; k++) begin
			for (int i = 0; i < 5; i++)
				dv[i] = 8'($urandom);
			// Limits never zero, so each covers at least one notional reference period
			dv[2] = 8'($urandom_range(255, 1));
			dv[3] = 8'($urandom_range(255, 1));
			// No reference clocks here, so any tolerance code suits them
			dv[4][2:0] = 3'(k);
			dv[4][6:4] = 3'(7 - k);
			// Notional references are taken as frequency locked when feedback is on
			for (int i = 0; i < 5; i++)
				axi_write(cfg_idx[i], dv[i], RESP_OKAY);
			for (int i = 0; i < 5; i++)
				axi_read(cfg_idx[i], {24'h0, (cfg_rst[i] & ~cfg_wm[i]) | (dv[i] & cfg_wm[i])},
					RESP_OKAY);
			#1;
			cmp_port({30'h0, fb_en, fb_src}, {30'h0, dv[0][7], dv[0][2]});
			cmp_port({28'h0, lp}, {28'h0, dv[1][3:0]});
			cmp_port({14'h0, bound0}, 32'(dv[2]) * PML_UNIT_CYC);
			cmp_port({14'h0, bound1}, 32'(dv[3]) * PML_UNIT_CYC);
			cmp_port({26'h0, scm_tol, cfm_tol}, {26'h0, dv[4][6:4], dv[4][2:0]});
		end
		// Holdover and lock levels read back live
		for (int k = 0; k < 4; k++) begin
			@(posedge aclk);
			{lock_in, hold_in} <= 2'(k);
			settle(8);
			axi_read(IDX_STATE, 32'(k), RESP_OKAY);
		end
		// Each failure type alone, with its holdover mask bit set then cleared
		for (int i = 0; i < 4; i++) begin
			fail_in <= 4'(1 << i);
			settle(8);
			axi_read(IDX_FAIL, 32'(1 << i), RESP_OKAY);
			axi_write(IDX_HOLD_MASK, 8'(1 << i), RESP_OKAY);
			settle(3);
			cmp_port({31'h0, hold_req}, 32'h1);
			axi_write(IDX_HOLD_MASK, 8'h0f & ~8'(1 << i), RESP_OKAY);
			settle(3);
			cmp_port({31'h0, hold_req}, 32'h0);
			axi_read(IDX_HOLD_MASK, {24'h0, 8'h80 | (8'h0f & ~8'(1 << i))}, RESP_OKAY);
		end
		fail_in <= 4'h0;
		settle(8);
		// Sticky event, masked, unmasked, then cleared by writing one
		axi_write(IDX_IRQ_ST, 8'h3f, RESP_OKAY);
		axi_read(IDX_IRQ_ST, 32'h0, RESP_OKAY);
		fail_in[2] <= 1'b1;
		settle(8);
		axi_read(IDX_IRQ_ST, 32'(1 << EV_CFM), RESP_OKAY);
		cmp_port({31'h0, irq}, 32'h0);
		axi_write(IDX_IRQ_MASK, 8'(1 << EV_CFM), RESP_OKAY);
		settle(3);
		cmp_port({31'h0, irq}, 32'h1);
		axi_write(IDX_IRQ_ST, 8'(1 << EV_CFM), RESP_OKAY);
		settle(3);
		cmp_port({31'h0, irq}, 32'h0);
		axi_read(IDX_IRQ_ST, 32'h0, RESP_OKAY);
		// A fresh rising edge with the mask still open raises the interrupt again
		fail_in[2] <= 1'b0;
		settle(8);
		@(posedge aclk);
		fail_in[2] <= 1'b1;
		settle(8);
		cmp_port({31'h0, irq}, 32'h1);
		axi_read(IDX_IRQ_ST, 32'(1 << EV_CFM), RESP_OKAY);
		settle(4);
		report_and_stop();
	end
endmodule : dsm_regs_test
